// ### rtl/osr_decode.sv
`timescale 1ns/100ps
// turns a two-bit oversampling field into one-hot scheme selects
module osr_decode (
   input  wire logic [1:0] osrField,
   output logic            selNormal,
   output logic            selLowNoise,
   output logic            selHighRes,
   output logic            selLowPower
);
   // every code maps to exactly one scheme
   always_comb begin
      selNormal   = (osrField == selftest_softreset_pkg::OSR_NORMAL);
      selLowNoise = (osrField == selftest_softreset_pkg::OSR_LN_LP);
      selHighRes  = (osrField == selftest_softreset_pkg::OSR_HIGH_RES);
      selLowPower = (osrField == selftest_softreset_pkg::OSR_LOW_POWER);
   end
endmodule : osr_decode

// ### rtl/selftest_softreset_ctrl.sv
`timescale 1ns/100ps
module selftest_softreset_ctrl (
   input  wire logic       mclk,
   input  wire logic       sys_rst,
   input  wire logic       regWrEn,
   input  wire logic       regRdEn,
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWrData,
   output logic      [7:0] regRdData,
   input  wire logic       extResetPin,
   output logic            selfCheckActive,
   output logic            axisOffsetEn,
   output logic            autoSleepEn,
   output logic            deviceActive,
   output logic            standbyDone,
   output logic            rebootBusy,
   output logic            funcBlockReset,
   output logic            serialIfReset,
   output logic            sleepNormal,
   output logic            sleepLowNoise,
   output logic            sleepHighRes,
   output logic            sleepLowPower,
   output logic            wakeNormal,
   output logic            wakeLowNoise,
   output logic            wakeHighRes,
   output logic            wakeLowPower
);
   // sequencer phases: idle takes register writes, standby drains an
   // active device before the boot, boot holds the defaults and the
   // serial engines in reset for a fixed span
   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_STANDBY,
      SEQ_BOOT
   } seq_state_t;

   // every piece of state lives in one struct so reset and update stay in step
   typedef struct packed {
      logic [7:0]                                 cfg;
      logic                                       active;
      seq_state_t                                 state;
      logic [selftest_softreset_pkg::CNT_W-1:0]   cnt;
      logic                                       extPinPrev;
      logic [7:0]                                 rdData;
   } ctrl_t;

   ctrl_t s_q;
   ctrl_t s_d;

   // request strobes decoded from the bus and the pin
   logic rebootReq;
   logic extPulse;

   // reload values: the phases count down to zero, hence one less than the span
   localparam logic [7:0] STBY_CNT =
      8'(selftest_softreset_pkg::STANDBY_CYCLES - 1);
   localparam logic [7:0] BOOT_CNT =
      8'(selftest_softreset_pkg::BOOT_CYCLES - 1);

   // address match for the self-check and sleep configuration register
   function automatic logic isCfgAddr(input logic [7:0] addr);
      return (addr == selftest_softreset_pkg::SELF_CHECK_SLEEP_CONFIG_ADDR);
   endfunction : isCfgAddr

   // address match for the standby/active control register
   function automatic logic isActiveAddr(input logic [7:0] addr);
      return (addr == selftest_softreset_pkg::ACTIVE_CTRL_ADDR);
   endfunction : isActiveAddr

   // one step of a phase counter; callers stop at zero so it never wraps
   function automatic logic [7:0] countDown(input logic [7:0] cnt);
      return cnt - 8'h01;
   endfunction : countDown

   // readback mux; unmapped addresses give zero rather than stale data
   function automatic logic [7:0] readBack(input logic [7:0] addr,
                                           input logic [7:0] cfg,
                                           input logic       active);
      logic [7:0] value;
      value = 8'h00;
      if (isCfgAddr(addr)) begin
         value = cfg & selftest_softreset_pkg::WRITE_MASK;
      end else if (isActiveAddr(addr)) begin
         value = {7'h00, active};
      end else begin
         value = 8'h00;
      end
      return value;
   endfunction : readBack

   // rising edge of the external reset pin starts a reboot; the edge
   // detector idles low like the pin, so no false pulse follows reset
   assign extPulse = extResetPin & ~s_q.extPinPrev;
   // software request: write with the reboot bit set, any mode
   assign rebootReq = regWrEn
                    && isCfgAddr(regAddr)
                    && regWrData[selftest_softreset_pkg::REBOOT_BIT];

   // next-state logic for the register file and reboot sequencer
   always_comb begin
      s_d            = s_q;
      s_d.extPinPrev = extResetPin;
      s_d.rdData     = s_q.rdData;
      // read data is registered and stands until the next read strobe
      if (regRdEn) begin
         s_d.rdData = readBack(regAddr, s_q.cfg, s_q.active);
      end
      case (s_q.state)
         SEQ_IDLE: begin
            // writes land only while no reboot is underway; a write that
            // arrives mid-reboot is dropped so the defaults stay intact
            if (regWrEn && isCfgAddr(regAddr)) begin
               s_d.cfg = regWrData & selftest_softreset_pkg::WRITE_MASK;
            end else if (regWrEn && isActiveAddr(regAddr)) begin
               s_d.active = regWrData[selftest_softreset_pkg::ACTIVE_BIT];
            end
            // pin pulse and software request share one entry point; an
            // active device drains first, a standby one boots at once
            if (rebootReq || extPulse) begin
               s_d.cfg[selftest_softreset_pkg::REBOOT_BIT] = 1'b1;
               s_d.active = 1'b0;
               if (s_q.active) begin
                  s_d.state = SEQ_STANDBY;
                  s_d.cnt   = STBY_CNT;
               end else begin
                  s_d.state = SEQ_BOOT;
                  s_d.cnt   = BOOT_CNT;
               end
            end
         end
         SEQ_STANDBY: begin
            // let the measurement chain wind down before booting; the
            // active bit is held low so conversion cannot restart
            s_d.active = 1'b0;
            if (s_q.cnt == 8'h00) begin
               // standby reached, only now may the boot begin
               s_d.state = SEQ_BOOT;
               s_d.cnt   = BOOT_CNT;
            end else begin
               s_d.cnt = countDown(s_q.cnt);
            end
         end
         SEQ_BOOT: begin
            // defaults reload every cycle; the reboot bit stays set until
            // the end so it reads back 1 while the boot runs
            s_d.cfg    = selftest_softreset_pkg::SELF_CHECK_SLEEP_CONFIG_RST;
            s_d.cfg[selftest_softreset_pkg::REBOOT_BIT] = 1'b1;
            s_d.active = 1'b0;
            if (s_q.cnt == 8'h00) begin
               // boot finished: hardware clears the request bit
               s_d.state = SEQ_IDLE;
               s_d.cfg[selftest_softreset_pkg::REBOOT_BIT] = 1'b0;
            end else begin
               s_d.cnt = countDown(s_q.cnt);
            end
         end
         default: begin
            // unused encoding: fall back to idle rather than lock up
            s_d.state = SEQ_IDLE;
         end
      endcase
   end

   // single register stage for all state; the reset values match
   // what a finished boot leaves behind, so both paths agree
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         s_q.cfg        <= selftest_softreset_pkg::SELF_CHECK_SLEEP_CONFIG_RST;
         s_q.active     <= 1'b0;
         s_q.state      <= SEQ_IDLE;
         s_q.cnt        <= 8'h00;
         s_q.extPinPrev <= 1'b0;
         s_q.rdData     <= 8'h00;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs from state flops
   assign regRdData       = s_q.rdData;
   assign selfCheckActive = s_q.cfg[selftest_softreset_pkg::SELF_CHECK_BIT];
   assign axisOffsetEn    = s_q.cfg[selftest_softreset_pkg::SELF_CHECK_BIT];
   assign autoSleepEn     = s_q.cfg[selftest_softreset_pkg::AUTO_SLEEP_BIT];
   assign deviceActive    = s_q.active;
   // standby is reported only once the drain phase is over
   assign standbyDone     = (s_q.state != SEQ_STANDBY) & ~s_q.active;
   // busy spans both phases so the host sees one unbroken reboot
   assign rebootBusy      = (s_q.state != SEQ_IDLE);
   assign funcBlockReset  = (s_q.state == SEQ_BOOT);
   // the serial engines are held in reset for the whole boot so half
   // received frames are dropped; the host must wait before talking
   assign serialIfReset   = (s_q.state == SEQ_BOOT);

   // sleep scheme decode
   osr_decode u_sleepDec (
      .osrField    (s_q.cfg[selftest_softreset_pkg::SLEEP_OSR_LSB +: 2]),
      .selNormal   (sleepNormal),
      .selLowNoise (sleepLowNoise),
      .selHighRes  (sleepHighRes),
      .selLowPower (sleepLowPower)
   );

   // wake scheme decode; same code table as the sleep field
   osr_decode u_wakeDec (
      .osrField    (s_q.cfg[selftest_softreset_pkg::WAKE_OSR_LSB +: 2]),
      .selNormal   (wakeNormal),
      .selLowNoise (wakeLowNoise),
      .selHighRes  (wakeHighRes),
      .selLowPower (wakeLowPower)
   );
endmodule : selftest_softreset_ctrl

// ### rtl/selftest_softreset_pkg.sv
package selftest_softreset_pkg;
   // register map
   localparam logic [7:0] SELF_CHECK_SLEEP_CONFIG_ADDR = 8'h2B;
   localparam logic [7:0] ACTIVE_CTRL_ADDR             = 8'h2A;
   localparam logic [7:0] SELF_CHECK_SLEEP_CONFIG_RST  = 8'h00;
   // field positions inside the config and active control registers
   localparam int SELF_CHECK_BIT = 7;
   localparam int REBOOT_BIT     = 6;
   localparam int UNUSED_BIT     = 5;
   localparam int SLEEP_OSR_LSB  = 3;
   localparam int AUTO_SLEEP_BIT = 2;
   localparam int WAKE_OSR_LSB   = 0;
   localparam int ACTIVE_BIT     = 0;
   // writable bits; the unused position is masked out
   localparam logic [7:0] WRITE_MASK = 8'hDF;
   // timing: standby drain and boot durations
   localparam int CLK_MHZ          = 100;
   localparam int STANDBY_DRAIN_NS = 100;
   localparam int STANDBY_CYCLES   = (STANDBY_DRAIN_NS * CLK_MHZ + 999) / 1000;
   localparam int BOOT_NS          = 200;
   localparam int BOOT_CYCLES      = (BOOT_NS * CLK_MHZ + 999) / 1000;
   localparam int HOST_WAIT_US     = 1000;
   localparam int HOST_WAIT_CYCLES = HOST_WAIT_US * CLK_MHZ;
   localparam int CNT_W            = 8;
   // oversampling schemes
   typedef enum logic [1:0] {
      OSR_NORMAL    = 2'h0,
      OSR_LN_LP     = 2'h1,
      OSR_HIGH_RES  = 2'h2,
      OSR_LOW_POWER = 2'h3
   } osr_mode_t;
endpackage : selftest_softreset_pkg

// ### sim/host_model.sv
`timescale 1ns/100ps
// host side of the register port; drives only on falling edges
module host_model #(
   parameter int WAIT_CYCLES = 50
) (
   input  wire logic       mclk,
   output logic            regWrEn,
   output logic            regRdEn,
   output logic      [7:0] regAddr,
   output logic      [7:0] regWrData,
   output logic            extResetPin
);
   // idle bus at time zero
   initial begin
      {regWrEn, regRdEn, extResetPin} = 3'h0;
      regAddr   = 8'h00;
      regWrData = 8'h00;
   end
   // one-cycle strobe per byte access
   task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      {regWrEn, regRdEn} = {wr, !wr};
      regAddr   = a;
      regWrData = d;
      @(negedge mclk);
      {regWrEn, regRdEn} = 2'h0;
      regWrData = ~d; // stale data not left on the bus
   endtask : acc
   // shortened wait keeps the run small; bus stays idle throughout
   task automatic quiet();
      repeat (WAIT_CYCLES) @(negedge mclk);
   endtask : quiet
   // high pulse on the reset pin, then the quiet wait
   task automatic pin_reset();
      @(negedge mclk);
      extResetPin = 1'h1;
      @(negedge mclk);
      extResetPin = 1'h0;
      quiet();
   endtask : pin_reset
endmodule : host_model

// ### sim/selftest_softreset_ctrl_chk.sv
`timescale 1ns/100ps
// reboot sequencing and field decode seen at the block edge
module selftest_softreset_ctrl_chk (
   input wire logic       mclk,
   input wire logic       sys_rst,
   input wire logic       regWrEn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic       extResetPin,
   input wire logic       selfCheckActive,
   input wire logic       axisOffsetEn,
   input wire logic       deviceActive,
   input wire logic       standbyDone,
   input wire logic       rebootBusy,
   input wire logic       funcBlockReset,
   input wire logic       serialIfReset,
   input wire logic       sleepNormal,
   input wire logic       sleepLowNoise,
   input wire logic       sleepHighRes,
   input wire logic       sleepLowPower
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // sequencing: 40 covers drain plus boot with margin
   a_offset_follows: assert property (
      axisOffsetEn == selfCheckActive) else $error("offset");
   a_write_starts: assert property (
      regWrEn && regAddr == 8'h2B && regWrData[6] && !rebootBusy |=> rebootBusy) else $error("sw");
   a_pin_starts: assert property (
      $rose(extResetPin) |=> rebootBusy) else $error("pin");
   a_busy_standby: assert property (
      rebootBusy |-> !deviceActive) else $error("standby");
   a_drain_first: assert property (
      rebootBusy && !standbyDone |-> !funcBlockReset) else $error("drain");
   a_serial_reset: assert property (
      funcBlockReset |-> serialIfReset && rebootBusy) else $error("serial");
   a_boot_ends: assert property (
      $rose(rebootBusy) |-> ##[1:40] !rebootBusy) else $error("end");
   a_boot_clears: assert property (
      $fell(rebootBusy) |-> !selfCheckActive && !deviceActive) else $error("clear");
   a_sleep_onehot: assert property (
      $onehot({sleepNormal, sleepLowNoise, sleepHighRes, sleepLowPower})) else $error("osr");
   a_check_write: assert property (
      regWrEn && regAddr == 8'h2B && !rebootBusy
      |=> selfCheckActive == $past(regWrData[7])) else $error("selfcheck");
   c_from_active: cover property ($fell(deviceActive) && rebootBusy);
   c_pin: cover property ($rose(extResetPin));
   c_done: cover property ($fell(rebootBusy));
endmodule : selftest_softreset_ctrl_chk
bind selftest_softreset_ctrl selftest_softreset_ctrl_chk chk_i (.*);

// ### sim/selftest_softreset_ctrl_tb.sv
`timescale 1ns/100ps
// register-level bench of the self-check and reboot controller
module selftest_softreset_ctrl_tb;
   logic       mclk, sys_rst, regWrEn, regRdEn, extResetPin, scA, axO, asE, devA, sbD, busy;
   logic       fbR, siR;
   logic [7:0] regAddr, regWrData, regRdData;
   logic [3:0] slp, wak;
   int         failures = 0;
   int         cmp_count = 0;
   host_model host_i (.mclk(mclk), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
      .regWrData(regWrData), .extResetPin(extResetPin));
   selftest_softreset_ctrl selftest_softreset_ctrl_i (.mclk(mclk), .sys_rst(sys_rst),
      .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
      .regRdData(regRdData), .extResetPin(extResetPin), .selfCheckActive(scA),
      .axisOffsetEn(axO), .autoSleepEn(asE), .deviceActive(devA), .standbyDone(sbD),
      .rebootBusy(busy), .funcBlockReset(fbR), .serialIfReset(siR), .sleepNormal(slp[3]),
      .sleepLowNoise(slp[2]), .sleepHighRes(slp[1]), .sleepLowPower(slp[0]),
      .wakeNormal(wak[3]), .wakeLowNoise(wak[2]), .wakeHighRes(wak[1]), .wakeLowPower(wak[0]));
   // compare helpers: bytes, and reads through the host
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         $display("BAD %0t %s", $time, m);
         failures++;
      end
   endtask : cmp
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      host_i.acc(1'h0, a, 8'h00);
      cmp(regRdData, exp, "read");
   endtask : rd
   // fields, decode codes and the unused bit
   task automatic t_fields();
      host_i.acc(1'h1, 8'h2B, 8'hBF);
      rd(8'h2B, 8'h9F);
      cmp({scA, axO, asE}, 8'h07, "on");
      for (int k = 0; k < 4; k++) begin
         host_i.acc(1'h1, 8'h2B, {3'h0, 2'(k), 1'h0, 2'(k)});
         cmp(slp, 8'h08 >> k, "sleep");
         cmp(wak, 8'h08 >> k, "wake");
         cmp({scA, asE}, 8'h00, "off");
      end
      rd(8'h10, 8'h00);
   endtask : t_fields
   // reboot from standby starts boot at once
   task automatic t_standby();
      host_i.acc(1'h1, 8'h2B, 8'hC4);
      cmp({busy, fbR, siR}, 8'h07, "boot");
      cmp(sbD, 8'h01, "standby");
      host_i.quiet();
      cmp(busy, 8'h00, "busy");
      rd(8'h2B, 8'h00);
   endtask : t_standby
   // reboot from active drains to standby first
   task automatic t_active();
      host_i.acc(1'h1, 8'h2A, 8'h01);
      rd(8'h2A, 8'h01);
      host_i.acc(1'h1, 8'h2B, 8'h58);
      cmp({devA, busy, fbR}, 8'h02, "drain");
      cmp({sbD, busy}, 8'h01, "draining");
      host_i.quiet();
      cmp({sbD, busy}, 8'h02, "settled");
      rd(8'h2B, 8'h00);
      rd(8'h2A, 8'h00);
   endtask : t_active
   // pin pulse behaves as the soft request
   task automatic t_pin();
      host_i.acc(1'h1, 8'h2B, 8'h84);
      host_i.pin_reset();
      rd(8'h2B, 8'h00);
   endtask : t_pin
   task automatic close_out();
      $display("failures=%0d comparisons=%0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : close_out
   initial begin
      mclk = 1'h0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      sys_rst = 1'h1;
      repeat (12) @(negedge mclk);
      sys_rst = 1'h0;
      rd(8'h2B, 8'h00);
      rd(8'h2A, 8'h00);
      t_fields();
      t_standby();
      t_active();
      t_pin();
      close_out();
   end
endmodule : selftest_softreset_ctrl_tb
